// ===== exc_entry_regs.vh
// Constants for the exception entry control block.
// Function
// - Reset outranks every trap and interrupt source and cancels any pending one.
// - Reset exception processing starts as soon as the external reset pin is released; here only after the two-stage pin synchroniser and a count to 2.
// - A watchdog overflow resets the chip and then runs the same entry as a pin reset.
// - Executing the software trap instruction starts exception processing.
// - The trap number 0 to 3 from the instruction selects the trap vector address.
// - A software trap is taken at any time, whatever the global mask bit holds.
// - While the global mask bit is 1 all interrupts except the non-maskable line and address break are blocked.
// - Interrupt entry begins only when the current instruction or exception sequence has completed.
// - Among several outstanding requests the one of highest fixed priority is served first.
// - Vectors are two-byte entries at fixed addresses, trap zero at 0010 to 0011.
`ifndef EXC_ENTRY_REGS_VH
`define EXC_ENTRY_REGS_VH

// ----------------------------------------------------------------------
// Vector numbers
// ----------------------------------------------------------------------
`define VEC_RESET      5'h00
`define VEC_NMI        5'h07
`define VEC_TRAP0      5'h08
`define VEC_ABRK       5'h0c
`define VEC_MASK_BASE  5'h0d
`define VEC_W          5
`define ADDR_W         16
`define N_MASKABLE     13
`define TRAP_W         2
`define POST_RESET_CYC 2'h2
`define REL_CNT_W      2
`define REL_CNT_INIT   2'h0
`define REL_CNT_STEP   2'h1

// ----------------------------------------------------------------------
// Positions in the synchronised request word
// ----------------------------------------------------------------------
`define REQ_NMI        0
`define REQ_ABRK       1
`define REQ_MASK_LSB   2

`endif

// ===== exc_sync2.v
// Two flip-flop synchroniser for a bus of asynchronous inputs.
module exc_sync2 #(
    parameter W = 1
) (
    // Clock and reset.
    input  wire         clk_i,
    input  wire         rst_n_i,
    // Data.
    input  wire [W-1:0] d_i,
    input  wire [W-1:0] init_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] stage1;

    // First stage is read only by the second stage.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            stage1 <= {W{1'b0}};
            q_o    <= {W{1'b0}};
        end else begin
            stage1 <= d_i ^ init_i;
            q_o    <= stage1;
        end
    end
endmodule

// ===== exc_entry_ctrl.v
// Exception entry control: reset, software trap and interrupt arbitration.
`include "exc_entry_regs.vh"
module exc_entry_ctrl (
    // Clock and reset.
    input  wire                    clk_i,
    input  wire                    rst_n_i,
    // Reset sources.
    input  wire                    chip_init_pin_n_i,
    input  wire                    wdt_overflow_i,
    // Sequencer status.
    input  wire                    insn_boundary_i,
    input  wire                    software_trap_op_i,
    input  wire [`TRAP_W-1:0]      trap_num_i,
    input  wire                    global_mask_i,
    // Interrupt requests, level held until acknowledged.
    input  wire                    nmi_req_i,
    input  wire                    addr_break_req_i,
    input  wire [`N_MASKABLE-1:0]  maskable_req_i,
    // Requests to the sequencer.
    output reg                     chip_reset_o,
    output reg                     exc_start_o,
    output reg  [`VEC_W-1:0]       vec_num_o,
    output reg  [`ADDR_W-1:0]      vec_addr_o,
    output reg                     irq_ack_o,
    output wire                    exc_busy_o
);
    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    // ST_RESET holds the chip while the pin is low or just released,
    // ST_WDT holds it after a watchdog overflow, ST_RUN is normal program
    // execution and ST_EXC covers one exception entry sequence.
    localparam [3:0] ST_RESET = 4'h1;
    localparam [3:0] ST_RUN   = 4'h2;
    localparam [3:0] ST_EXC   = 4'h4;
    localparam [3:0] ST_WDT   = 4'h8;

    // ------------------------------------------------------------------
    // Internal signals
    // ------------------------------------------------------------------
    reg  [3:0]                state;
    reg  [3:0]                next_state;
    reg  [`REL_CNT_W-1:0]     rel_cnt;
    wire [`N_MASKABLE+1:0]    req_s;
    wire [`N_MASKABLE-1:0]    mask_open;
    wire                      reset_entry;
    wire                      wdt_restart;
    reg  [`VEC_W-1:0]         sel_vec;
    reg                       sel_hit;
    reg                       pin_s1;
    reg                       pin_s2;
    integer                   i;
    genvar                    g;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    // Vector number to address: two bytes per entry.
    function [`ADDR_W-1:0] vec_to_addr;
        input [`VEC_W-1:0] v;
        begin
            vec_to_addr = {{(`ADDR_W-`VEC_W-1){1'b0}}, v, 1'b0};
        end
    endfunction

    // Trap number to vector number: the four trap slots follow each other.
    function [`VEC_W-1:0] trap_vec;
        input [`TRAP_W-1:0] n;
        begin
            trap_vec = `VEC_TRAP0 + {{(`VEC_W-`TRAP_W){1'b0}}, n};
        end
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Request lines come from pins and other clock domains, so each one
    // passes two flip-flops before the priority logic looks at it. The
    // price is two cycles of latency on every interrupt request.
    exc_sync2 #(.W(`N_MASKABLE+`REQ_MASK_LSB)) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({maskable_req_i, addr_break_req_i, nmi_req_i}),
        .init_i  ({(`N_MASKABLE+`REQ_MASK_LSB){1'b0}}),
        .q_o     (req_s)
    );

    // Reset pin synchroniser, inverted to active high. It wakes up
    // asserted so that the chip stays held until the pin is seen high.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end else begin
            pin_s1 <= ~chip_init_pin_n_i;
            pin_s2 <= pin_s1;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt selection
    // ------------------------------------------------------------------
    // Each maskable line is held back while the global mask bit is set.
    // The request stays raised at its source, so it is served at the
    // first boundary after the mask opens again.
    generate
        for (g = 0; g < `N_MASKABLE; g = g + 1) begin : g_gate
            assign mask_open[g] = req_s[g+`REQ_MASK_LSB] &
                                  ~global_mask_i;
        end
    endgenerate

    // Priority pick: non-maskable line first, then address break, then
    // maskable line 0 down to line 12. Later assignments win, so the
    // loop walks from the lowest priority upwards.
    always @* begin
        sel_vec = `VEC_RESET;
        sel_hit = 1'b0;
        for (i = `N_MASKABLE - 1; i >= 0; i = i - 1) begin
            if (mask_open[i]) begin
                sel_vec = `VEC_MASK_BASE + i[`VEC_W-1:0];
                sel_hit = 1'b1;
            end
        end
        if (req_s[`REQ_ABRK]) begin
            sel_vec = `VEC_ABRK;
            sel_hit = 1'b1;
        end
        if (req_s[`REQ_NMI]) begin
            sel_vec = `VEC_NMI;
            sel_hit = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    // A fresh watchdog overflow restarts the hold even while an earlier
    // one still holds the chip, so every overflow gets a full reset.
    assign wdt_restart = wdt_overflow_i && !pin_s2;
    // The reset vector is fetched when leaving either hold state.
    assign reset_entry = (state == ST_RESET) || (state == ST_WDT);

    // Next state. Reset sources are checked last so that they override
    // whatever the sequencing below has chosen.
    always @* begin
        next_state = state;
        case (state)
            ST_RESET: begin
                if (!pin_s2 && rel_cnt == `POST_RESET_CYC)
                    next_state = ST_EXC;
            end
            ST_WDT: begin
                if (rel_cnt == `POST_RESET_CYC)
                    next_state = ST_EXC;
            end
            ST_RUN: begin
                if (insn_boundary_i && (software_trap_op_i || sel_hit))
                    next_state = ST_EXC;
            end
            ST_EXC: begin
                if (insn_boundary_i)
                    next_state = ST_RUN;
            end
            default: next_state = ST_RESET;
        endcase
        if (pin_s2)
            next_state = ST_RESET;
        else if (wdt_overflow_i)
            next_state = ST_WDT;
    end

    // The sequencer sees the block busy outside normal execution, so it
    // knows that no new request can be taken until this drops.
    assign exc_busy_o = (state != ST_RUN);

    // ------------------------------------------------------------------
    // State and registered outputs
    // ------------------------------------------------------------------
    // State, release counter and the entry outputs. Vector outputs hold
    // their value until the next entry.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state        <= ST_RESET;
            rel_cnt      <= `REL_CNT_INIT;
            chip_reset_o <= 1'b1;
            exc_start_o  <= 1'b0;
            irq_ack_o    <= 1'b0;
            vec_num_o    <= `VEC_RESET;
            vec_addr_o   <= {`ADDR_W{1'b0}};
        end else begin
            state       <= next_state;
            exc_start_o <= 1'b0;
            irq_ack_o   <= 1'b0;
            // The release counter runs only once the hold source is gone;
            // any fresh reset request starts it from zero again.
            if (next_state == ST_RESET || next_state == ST_WDT) begin
                chip_reset_o <= 1'b1;
                if (state != next_state || pin_s2 || wdt_restart)
                    rel_cnt <= `REL_CNT_INIT;
                else if (rel_cnt != `POST_RESET_CYC)
                    rel_cnt <= rel_cnt + `REL_CNT_STEP;
            end else begin
                chip_reset_o <= 1'b0;
                rel_cnt      <= `REL_CNT_INIT;
            end
            // Entry: reset vector, then trap, then the picked interrupt.
            if (next_state == ST_EXC && state != ST_EXC) begin
                exc_start_o <= 1'b1;
                if (reset_entry) begin
                    vec_num_o  <= `VEC_RESET;
                    vec_addr_o <= vec_to_addr(`VEC_RESET);
                end else if (software_trap_op_i) begin
                    vec_num_o  <= trap_vec(trap_num_i);
                    vec_addr_o <= vec_to_addr(trap_vec(trap_num_i));
                end else begin
                    // The acknowledge lets the source drop its line.
                    vec_num_o  <= sel_vec;
                    vec_addr_o <= vec_to_addr(sel_vec);
                    irq_ack_o  <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== exc_entry_ctrl_assertions.sv
// Port checker for the exception entry control block.
`include "exc_entry_regs.vh"
module exc_entry_ctrl_assertions (
    input wire clk_i, rst_n_i, chip_init_pin_n_i, wdt_overflow_i,
    input wire insn_boundary_i, software_trap_op_i, global_mask_i,
    input wire nmi_req_i, addr_break_req_i, chip_reset_o, exc_start_o,
    input wire irq_ack_o, exc_busy_o,
    input wire [`TRAP_W-1:0]     trap_num_i,
    input wire [`N_MASKABLE-1:0] maskable_req_i,
    input wire [`VEC_W-1:0]      vec_num_o,
    input wire [`ADDR_W-1:0]     vec_addr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // All checks run on the system clock and sleep during reset.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_wdt_resets: assert property (wdt_overflow_i |=> chip_reset_o)
        else $error("no chip reset");
    chk_reset_quiet: assert property (chip_reset_o |-> !exc_start_o && !irq_ack_o)
        else $error("entry in reset");
    chk_reset_vec: assert property ($fell(chip_reset_o) |-> exc_start_o && vec_num_o == 5'h00)
        else $error("bad reset entry");
    chk_trap_take: assert property (insn_boundary_i && software_trap_op_i && !exc_busy_o
        && !chip_reset_o && !wdt_overflow_i
        && $past(chip_init_pin_n_i, 2) |=> exc_start_o
        && vec_num_o == {3'h2, $past(trap_num_i)})
        else $error("trap not taken");
    chk_vec_pair: assert property (exc_start_o |-> vec_addr_o == {10'h0, vec_num_o, 1'b0})
        else $error("bad vector address");
    chk_mask_block: assert property (irq_ack_o && $past(global_mask_i)
        |-> vec_num_o inside {5'h07, 5'h0c})
        else $error("masked request taken");
    chk_ack_start: assert property (irq_ack_o |-> exc_start_o && vec_num_o > 5'h06)
        else $error("stray ack");
    chk_start_cause: assert property (exc_start_o && !$past(chip_reset_o)
        |-> $past(insn_boundary_i) && !$past(exc_busy_o))
        else $error("entry off boundary");
    cover property (exc_start_o && irq_ack_o);
    cover property ($fell(chip_reset_o));
    cover property (exc_start_o && vec_num_o == 5'h0b);
endmodule
bind exc_entry_ctrl exc_entry_ctrl_assertions chk (.*);

// ===== exc_seq_model.sv
// Sequencer and request sources facing the exception entry block.
module exc_seq_model (
    input  wire        clk_i,
    input  wire [2:0]  gap_i,
    input  wire        trap_req_i,
    input  wire [14:0] set_req_i,
    input  wire        chip_reset_i,
    input  wire        irq_ack_i,
    input  wire [4:0]  vec_num_i,
    output reg         insn_boundary_o = 1'b0,
    output reg         software_trap_op_o = 1'b0,
    output reg  [14:0] req_o = 15'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    reg  [2:0] cnt  = 3'h0;
    reg        pend = 1'b0;
    reg        trap_q = 1'b0;
    reg [14:0] set_q  = 15'h0;
    // Bench requests are taken mid-cycle, away from the bench's own edge.
    always @(posedge clk_i) begin
        trap_q <= trap_req_i;
        set_q  <= set_req_i;
    end
    wire       b    = cnt >= gap_i;
    wire [3:0] idx  = vec_num_i == 5'h07 ? 4'h0 : vec_num_i == 5'h0c ? 4'h1
                    : 4'(vec_num_i - 5'h0b);
    // Boundary every gap_i+1 cycles; a trap rides on the next one.
    always @(negedge clk_i) begin
        cnt <= b ? 3'h0 : cnt + 3'h1;
        insn_boundary_o <= b;
        software_trap_op_o <= pend && b;
        pend <= (pend || trap_q) && !(pend && b);
        // Sources drop a request once served, all of them on chip reset.
        req_o <= chip_reset_i ? 15'h0
               : (req_o | set_q) & ~(irq_ack_i ? 15'h1 << idx : 15'h0);
    end
endmodule

// ===== cpu_exception_entry_control_test.sv
// Self-checking bench for the exception entry control block.
module cpu_exception_entry_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    reg clk_i = 0, rst_n_i = 0, pin_n = 1, wdt = 0, mask = 0, trq = 0;
    reg  [1:0]  tnum = 2'h0;
    reg  [2:0]  gap  = 3'h1;
    reg  [14:0] sreq = 15'h0;
    wire        bnd, top, cr, st, ack, busy;
    wire [14:0] req;
    wire [4:0]  vn;
    wire [15:0] va;
    int error_cnt = 0, check_count = 0, cyc = 0, k, n;
    logic [4:0] v;
    logic [4:0] eq[$];
    always #50 clk_i = ~clk_i;
    exc_entry_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .chip_init_pin_n_i(pin_n),
        .wdt_overflow_i(wdt), .insn_boundary_i(bnd), .software_trap_op_i(top),
        .trap_num_i(tnum), .global_mask_i(mask), .nmi_req_i(req[0]),
        .addr_break_req_i(req[1]), .maskable_req_i(req[14:2]), .chip_reset_o(cr),
        .exc_start_o(st), .vec_num_o(vn), .vec_addr_o(va), .irq_ack_o(ack),
        .exc_busy_o(busy));
    exc_seq_model seq (.clk_i(clk_i), .gap_i(gap), .trap_req_i(trq),
        .set_req_i(sreq), .chip_reset_i(cr), .irq_ack_i(ack), .vec_num_i(vn),
        .insn_boundary_o(bnd), .software_trap_op_o(top), .req_o(req));
    task check(input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Drives one cycle of requests, trap and watchdog pulse.
    task poke(input [14:0] m, input t, w);
        sreq = m; trq = t; wdt = w;
        @(negedge clk_i);
        sreq = 15'h0; trq = 0; wdt = 0;
    endtask
    // Waits until all noted entries came and the core runs again.
    task settle;
        for (int i = 0; i < 300 && (eq.size() || busy || cr); i++) @(negedge clk_i);
        repeat (6) @(negedge clk_i);
        check(eq.size(), 0);
        check({cr, busy}, 2'h0);
        $display("test done");
    endtask
    // Each entry is matched against the oldest noted vector.
    always @(negedge clk_i) begin
        if (++cyc > 4000) begin
            error_cnt++;
            wrap_up;
        end else if (st) begin
            v = eq.size() ? eq.pop_front() : 5'h1f;
            check(vn, v);
            check(va, {v, 1'b0});
            check(ack, v == 5'h07 || v >= 5'h0c);
        end
    end
    initial begin
        void'($urandom(32'h89f055d7));
        eq.push_back(5'h00);
        repeat (4) @(negedge clk_i);
        rst_n_i = 1;
        settle;
        for (k = 0; k < 8; k++) begin
            gap = k[2] ? 3'h5 : 3'h1;
            mask = k[0];
            tnum = 2'($urandom);
            eq.push_back({3'h2, tnum});
            poke(15'h0, 1, 0);
            settle;
        end
        n = $urandom % 13;
        mask = 1;
        poke(15'h4 << n, 0, 0);
        repeat (20) @(negedge clk_i);
        eq.push_back(5'h07);
        poke(15'h1, 0, 0);
        settle;
        eq.push_back(5'h0d + 5'(n));
        mask = 0;
        settle;
        eq = '{5'h07, 5'h0c, 5'h0d};
        poke(15'h7, 0, 0);
        settle;
        eq.push_back(5'h00);
        poke(15'h4 << n, 0, 1);
        check(cr, 1);
        settle;
        eq.push_back(5'h00);
        pin_n = 0;
        repeat (6) @(negedge clk_i);
        check(cr, 1);
        pin_n = 1;
        settle;
        wrap_up;
    end
endmodule
